// [hdl/tmr_pkg.sv]
package tmr_pkg;

	// ----------------------------------------------------------
	// Bus layout.
	// ----------------------------------------------------------
	localparam int DW = 16;
	localparam int AW = 8;
	localparam int NCH = 4;
	localparam logic [AW-1:0] ADDR_CTRL = 8'h00;
	localparam logic [AW-1:0] ADDR_DMA_EN = 8'h08;
	localparam logic [AW-1:0] ADDR_IRQ_EN = 8'h0C;
	localparam logic [AW-1:0] ADDR_STS = 8'h10;
	localparam logic [AW-1:0] ADDR_CEG = 8'h14;
	localparam logic [AW-1:0] ADDR_CNT = 8'h24;
	localparam logic [AW-1:0] ADDR_PSC = 8'h28;
	localparam logic [AW-1:0] ADDR_ARR = 8'h2C;
	localparam logic [AW-1:0] ADDR_CC_BASE = 8'h34;
	localparam logic [AW-1:0] ADDR_CC_STEP = 8'h04;
	localparam logic [AW-1:0] ADDR_IRQ_PEND = 8'h44;

	// ----------------------------------------------------------
	// Field positions.
	// ----------------------------------------------------------
	localparam int STS_UPD = 0;
	localparam int STS_CH = 1;
	localparam int STS_COM = 5;
	localparam int STS_TRG = 6;
	localparam int STS_BRK = 7;
	localparam int STS_OVC = 9;
	localparam int CEG_UPD = 0;
	localparam int CEG_CH = 1;
	localparam int CEG_W = 4;
	localparam int DMA_CH = 1;

	// ----------------------------------------------------------
	// Reset values and masks.
	// ----------------------------------------------------------
	localparam logic [DW-1:0] RST_REG = 16'h0000;
	localparam logic [DW-1:0] CTRL_MASK = 16'h00F7;
	localparam logic [DW-1:0] EN_MASK = 16'h1EFF;

	// Control word: counting mode and per channel direction.
	typedef struct packed {
		logic [7:0] unused;
		logic [3:0] chan_input;
		logic rsv;
		logic center;
		logic down;
		logic en;
	} ctrl_t;

endpackage : tmr_pkg

// [hdl/chan_unit.sv]
`timescale 1ns/1ps
module chan_unit #(
	parameter int W = 16
) (
	// Clock and reset.
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	// Mode and events.
	input wire logic i_is_input,
	input wire logic i_cap,
	input wire logic i_force,
	input wire logic i_tick,
	input wire logic [W-1:0] i_cnt,
	// Software access.
	input wire logic i_wr_val,
	input wire logic [W-1:0] i_wdata,
	input wire logic i_clr_flag,
	input wire logic i_clr_ovc,
	input wire logic i_rd_val,
	// State.
	output logic o_flag,
	output logic o_ovc,
	output logic [W-1:0] o_value,
	output logic o_set
);

	logic cap;
	logic hit;
	logic set;
	logic next_flag;
	logic next_ovc;
	logic next_set;
	logic [W-1:0] next_value;

	// Capture and compare share one flag; a set beats any clear.
	always_comb begin
		cap = i_is_input & (i_cap | i_force);
		hit = ~i_is_input & ((i_tick & (i_cnt == o_value)) | i_force);
		set = cap | hit;
		next_set = set;
		next_flag = set | (o_flag & ~i_clr_flag & ~i_rd_val);
		next_ovc = (cap & o_flag) | (o_ovc & ~i_clr_ovc);
		next_value = o_value;
		if (cap) begin
			next_value = i_cnt;
		end else if (i_wr_val & ~i_is_input) begin
			next_value = i_wdata;
		end
	end

	// Channel state registers.
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			o_flag <= 1'b0;
			o_ovc <= 1'b0;
			o_set <= 1'b0;
			o_value <= '0;
		end else begin
			o_flag <= next_flag;
			o_ovc <= next_ovc;
			o_set <= next_set;
			o_value <= next_value;
		end
	end

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);

	a_capture_value: assert property (
		i_is_input && (i_cap || i_force) |=>
		o_value == $past(i_cnt) && o_flag)
		else $error("capture value not taken");
	a_repeat_capture: assert property (
		i_is_input && i_cap && o_flag |=> o_ovc)
		else $error("overcapture flag not set");
	a_forced_repeat: assert property (
		i_is_input && i_force && o_flag && !i_clr_ovc |=> o_ovc)
		else $error("forced overcapture flag missing");
	a_read_clear: assert property (
		o_flag && i_rd_val && !i_cap && !i_force && !i_tick
		|=> !o_flag)
		else $error("flag not cleared by value read");

endmodule : chan_unit

// [hdl/timer_status_evgen.sv]
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module timer_status_evgen (
	// Clock and reset.
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	// Register port.
	input wire logic [tmr_pkg::AW-1:0] i_addr,
	input wire logic [tmr_pkg::DW-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [tmr_pkg::DW-1:0] o_rdata,
	// Event sources.
	input wire logic i_trigger_evt,
	input wire logic i_commutation_evt,
	input wire logic i_brake_pin,
	input wire logic [tmr_pkg::NCH-1:0] i_chan_pin,
	// Event outputs.
	output logic o_irq,
	output logic [tmr_pkg::NCH-1:0] o_dma_req,
	output logic o_update_evt,
	output logic [tmr_pkg::DW-1:0] o_counter
);

	localparam int NCH = tmr_pkg::NCH;
	localparam int NPIN = NCH + 1;

	// ----------------------------------------------------------
	// Pin synchronisers.
	// ----------------------------------------------------------
	logic [NPIN-1:0] s1;
	logic [NPIN-1:0] s2;
	logic [NPIN-1:0] s3;
	logic [NPIN-1:0] pin_st;
	logic [NPIN-1:0] next_s1;
	logic [NPIN-1:0] next_pin_st;
	logic [NCH-1:0] cap_rise;
	logic brake_on;

	// A pin level counts only once the last two stages agree.
	always_comb begin
		next_s1 = {i_brake_pin, i_chan_pin};
		for (int b = 0; b < NPIN; b++) begin
			next_pin_st[b] = (s2[b] == s3[b]) ? s3[b] : pin_st[b];
		end
		cap_rise = next_pin_st[NCH-1:0] & ~pin_st[NCH-1:0];
		brake_on = pin_st[NCH];
	end

	// Synchroniser stages.
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			pin_st <= '0;
		end else begin
			s1 <= next_s1;
			s2 <= s1;
			s3 <= s2;
			pin_st <= next_pin_st;
		end
	end

	// ----------------------------------------------------------
	// Register file.
	// ----------------------------------------------------------
	tmr_pkg::ctrl_t ctrl;
	tmr_pkg::ctrl_t next_ctrl;
	logic [tmr_pkg::DW-1:0] dma_en;
	logic [tmr_pkg::DW-1:0] irq_en;
	logic [tmr_pkg::DW-1:0] psc;
	logic [tmr_pkg::DW-1:0] arr;
	logic [tmr_pkg::DW-1:0] next_dma_en;
	logic [tmr_pkg::DW-1:0] next_irq_en;
	logic [tmr_pkg::DW-1:0] next_psc;
	logic [tmr_pkg::DW-1:0] next_arr;
	logic [tmr_pkg::CEG_W-1:0] ceg;
	logic [tmr_pkg::CEG_W-1:0] next_ceg;
	logic wr_sts;
	logic wr_ceg;
	logic wr_psc;
	logic rd_pend;
	logic [NCH-1:0] wr_cc;
	logic [NCH-1:0] rd_cc;
	logic [tmr_pkg::DW-1:0] sts_clr;
	logic force_upd;
	logic [NCH-1:0] force_ch;

	// Address decode and software writes.
	always_comb begin
		wr_sts = i_wr && (i_addr == tmr_pkg::ADDR_STS);
		wr_ceg = i_wr && (i_addr == tmr_pkg::ADDR_CEG);
		wr_psc = i_wr && (i_addr == tmr_pkg::ADDR_PSC);
		rd_pend = i_rd && (i_addr == tmr_pkg::ADDR_IRQ_PEND);
		for (int k = 0; k < NCH; k++) begin
			wr_cc[k] = i_wr && (i_addr == tmr_pkg::ADDR_CC_BASE
				+ tmr_pkg::AW'(k) * tmr_pkg::ADDR_CC_STEP);
			rd_cc[k] = i_rd && (i_addr == tmr_pkg::ADDR_CC_BASE
				+ tmr_pkg::AW'(k) * tmr_pkg::ADDR_CC_STEP);
		end
		sts_clr = wr_sts ? ~i_wdata : '0;
		next_ctrl = ctrl;
		next_dma_en = dma_en;
		next_irq_en = irq_en;
		next_psc = psc;
		next_arr = arr;
		if (i_wr && (i_addr == tmr_pkg::ADDR_CTRL)) begin
			next_ctrl = tmr_pkg::ctrl_t'(i_wdata & tmr_pkg::CTRL_MASK);
		end
		if (i_wr && (i_addr == tmr_pkg::ADDR_DMA_EN)) begin
			next_dma_en = i_wdata & tmr_pkg::EN_MASK;
		end
		if (i_wr && (i_addr == tmr_pkg::ADDR_IRQ_EN)) begin
			next_irq_en = i_wdata & tmr_pkg::EN_MASK;
		end
		if (wr_psc) begin
			next_psc = i_wdata;
		end
		if (i_wr && (i_addr == tmr_pkg::ADDR_ARR)) begin
			next_arr = i_wdata;
		end
		// Force bits live one cycle, then fall back to zero.
		next_ceg = wr_ceg ? i_wdata[tmr_pkg::CEG_W-1:0] : '0;
		force_upd = ceg[tmr_pkg::CEG_UPD];
		// Channel 4 has no force bit in this block.
		force_ch = {1'b0, ceg[tmr_pkg::CEG_W-1:tmr_pkg::CEG_CH]};
	end

	// Software visible registers.
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			ctrl <= tmr_pkg::ctrl_t'(tmr_pkg::RST_REG);
			dma_en <= tmr_pkg::RST_REG;
			irq_en <= tmr_pkg::RST_REG;
			psc <= tmr_pkg::RST_REG;
			arr <= tmr_pkg::RST_REG;
			ceg <= '0;
		end else begin
			ctrl <= next_ctrl;
			dma_en <= next_dma_en;
			irq_en <= next_irq_en;
			psc <= next_psc;
			arr <= next_arr;
			ceg <= next_ceg;
		end
	end

	// ----------------------------------------------------------
	// Counter and prescaler.
	// ----------------------------------------------------------
	logic [tmr_pkg::DW-1:0] cnt;
	logic [tmr_pkg::DW-1:0] psc_cnt;
	logic ctr_dn;
	logic [tmr_pkg::DW-1:0] next_cnt;
	logic [tmr_pkg::DW-1:0] next_psc_cnt;
	logic next_ctr_dn;
	logic cnt_tick;
	logic ovf;
	logic upd_evt;
	logic load_top;

	// A forced update outranks any count step in the same cycle.
	always_comb begin
		next_cnt = cnt;
		next_psc_cnt = psc_cnt;
		next_ctr_dn = ctr_dn;
		cnt_tick = 1'b0;
		ovf = 1'b0;
		load_top = ctrl.down && !ctrl.center;
		if (force_upd) begin
			next_psc_cnt = '0;
			next_cnt = load_top ? arr : '0;
			next_ctr_dn = load_top;
		end else if (ctrl.en) begin
			if (psc_cnt >= psc) begin
				next_psc_cnt = '0;
				cnt_tick = 1'b1;
			end else begin
				next_psc_cnt = psc_cnt + 16'h0001;
			end
		end
		if (cnt_tick) begin
			if (ctrl.center) begin
				if (!ctr_dn && (cnt >= arr)) begin
					next_ctr_dn = 1'b1;
					next_cnt = cnt - 16'h0001;
					ovf = 1'b1;
				end else if (ctr_dn && (cnt == '0)) begin
					next_ctr_dn = 1'b0;
					next_cnt = cnt + 16'h0001;
					ovf = 1'b1;
				end else begin
					next_cnt = ctr_dn ? cnt - 16'h0001 : cnt + 16'h0001;
				end
			end else if (ctrl.down) begin
				ovf = (cnt == '0);
				next_cnt = ovf ? arr : cnt - 16'h0001;
			end else begin
				ovf = (cnt >= arr);
				next_cnt = ovf ? '0 : cnt + 16'h0001;
			end
		end
		upd_evt = force_upd | ovf;
	end

	// Counter registers.
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			cnt <= '0;
			psc_cnt <= '0;
			ctr_dn <= 1'b0;
		end else begin
			cnt <= next_cnt;
			psc_cnt <= next_psc_cnt;
			ctr_dn <= next_ctr_dn;
		end
	end

	// ----------------------------------------------------------
	// Capture and compare channels.
	// ----------------------------------------------------------
	logic [NCH-1:0] ch_flag;
	logic [NCH-1:0] ch_ovc;
	logic [NCH-1:0] ch_set;
	logic [tmr_pkg::DW-1:0] ch_val [NCH];

	for (genvar g = 0; g < NCH; g++) begin : g_ch
		chan_unit #(.W(tmr_pkg::DW)) u_ch (
			.i_ref_clk(i_ref_clk),
			.i_nrst(i_nrst),
			.i_is_input(ctrl.chan_input[g]),
			.i_cap(cap_rise[g]),
			.i_force(force_ch[g]),
			.i_tick(cnt_tick),
			.i_cnt(cnt),
			.i_wr_val(wr_cc[g]),
			.i_wdata(i_wdata),
			.i_clr_flag(sts_clr[tmr_pkg::STS_CH + g]),
			.i_clr_ovc(sts_clr[tmr_pkg::STS_OVC + g]),
			.i_rd_val(rd_cc[g]),
			.o_flag(ch_flag[g]),
			.o_ovc(ch_ovc[g]),
			.o_value(ch_val[g]),
			.o_set(ch_set[g])
		);
	end

	// ----------------------------------------------------------
	// Status flags, pending events and outputs.
	// ----------------------------------------------------------
	logic upd_f;
	logic com_f;
	logic trg_f;
	logic brk_f;
	logic [NCH-1:0] ovc_prev;
	logic [tmr_pkg::DW-1:0] pend;
	logic [tmr_pkg::DW-1:0] sts;
	logic [tmr_pkg::DW-1:0] ev;
	logic next_upd_f;
	logic next_com_f;
	logic next_trg_f;
	logic next_brk_f;
	logic [tmr_pkg::DW-1:0] next_pend;
	logic [tmr_pkg::DW-1:0] next_rdata;
	logic [NCH-1:0] next_dma;
	logic next_irq;

	// Every hardware set wins over a clear arriving alongside.
	always_comb begin
		next_upd_f = upd_evt | (upd_f & ~sts_clr[tmr_pkg::STS_UPD]);
		next_com_f = i_commutation_evt
			| (com_f & ~sts_clr[tmr_pkg::STS_COM]);
		next_trg_f = i_trigger_evt
			| (trg_f & ~sts_clr[tmr_pkg::STS_TRG]);
		// A clear while the brake is still active has no effect.
		next_brk_f = brake_on | (brk_f & ~sts_clr[tmr_pkg::STS_BRK]);
		sts = '0;
		ev = '0;
		sts[tmr_pkg::STS_UPD] = upd_f;
		sts[tmr_pkg::STS_COM] = com_f;
		sts[tmr_pkg::STS_TRG] = trg_f;
		sts[tmr_pkg::STS_BRK] = brk_f;
		ev[tmr_pkg::STS_UPD] = upd_evt;
		ev[tmr_pkg::STS_COM] = i_commutation_evt;
		ev[tmr_pkg::STS_TRG] = i_trigger_evt;
		ev[tmr_pkg::STS_BRK] = brake_on;
		for (int k = 0; k < NCH; k++) begin
			sts[tmr_pkg::STS_CH + k] = ch_flag[k];
			sts[tmr_pkg::STS_OVC + k] = ch_ovc[k];
			ev[tmr_pkg::STS_CH + k] = ch_set[k];
			ev[tmr_pkg::STS_OVC + k] = ch_ovc[k] & ~ovc_prev[k];
			next_dma[k] = ch_set[k] & dma_en[tmr_pkg::DMA_CH + k];
		end
		next_pend = ev | (pend & ~{tmr_pkg::DW{rd_pend}});
		next_irq = |(next_pend & irq_en);
		next_rdata = '0;
		if (i_rd) begin
			case (i_addr)
				tmr_pkg::ADDR_CTRL: next_rdata = ctrl;
				tmr_pkg::ADDR_DMA_EN: next_rdata = dma_en;
				tmr_pkg::ADDR_IRQ_EN: next_rdata = irq_en;
				tmr_pkg::ADDR_STS: next_rdata = sts;
				tmr_pkg::ADDR_CNT: next_rdata = cnt;
				tmr_pkg::ADDR_PSC: next_rdata = psc;
				tmr_pkg::ADDR_ARR: next_rdata = arr;
				tmr_pkg::ADDR_IRQ_PEND: next_rdata = pend;
				default: next_rdata = '0;
			endcase
			for (int k = 0; k < NCH; k++) begin
				if (rd_cc[k]) begin
					next_rdata = ch_val[k];
				end
			end
		end
	end

	// Flag and output registers.
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			upd_f <= 1'b0;
			com_f <= 1'b0;
			trg_f <= 1'b0;
			brk_f <= 1'b0;
			ovc_prev <= '0;
			pend <= '0;
			o_rdata <= '0;
			o_irq <= 1'b0;
			o_dma_req <= '0;
			o_update_evt <= 1'b0;
		end else begin
			upd_f <= next_upd_f;
			com_f <= next_com_f;
			trg_f <= next_trg_f;
			brk_f <= next_brk_f;
			ovc_prev <= ch_ovc;
			pend <= next_pend;
			o_rdata <= next_rdata;
			o_irq <= next_irq;
			o_dma_req <= next_dma;
			o_update_evt <= upd_evt;
		end
	end

	assign o_counter = cnt;

	// ----------------------------------------------------------
	// Checks.
	// ----------------------------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);

	a_chan34_flags: assert property (
		ch_set[2] && ch_set[3] |-> sts[3] && sts[4] ##0 ch_flag[3])
		else $error("channel 3 or 4 flag missing");
	a_commutation_flag: assert property (
		i_commutation_evt |=> com_f && sts[tmr_pkg::STS_COM])
		else $error("commutation flag not set");
	a_trigger_flag: assert property (
		i_trigger_evt |=> trg_f)
		else $error("trigger flag not set");
	a_brake_hold: assert property (
		brake_on |=> brk_f)
		else $error("brake flag cleared while brake active");
	a_update_force: assert property (
		wr_ceg && i_wdata[tmr_pkg::CEG_UPD] |-> ##2 o_update_evt && upd_f)
		else $error("forced update missing");
	a_ceg_selfclear: assert property (
		ceg != '0 && !wr_ceg |=> ceg == '0)
		else $error("event bits did not self clear");
	a_prescale_reset: assert property (
		force_upd && !wr_psc |=> psc_cnt == '0 && psc == $past(psc))
		else $error("prescaler not reset on update");
	a_update_zero: assert property (
		force_upd && !load_top |=> cnt == '0)
		else $error("counter not zeroed on update");
	a_update_reload: assert property (
		force_upd && load_top |=> cnt == $past(arr))
		else $error("counter not reloaded on update");
	a_force_chan1: assert property (
		wr_ceg && i_wdata[tmr_pkg::CEG_CH] |-> ##2 ch_flag[0] && ch_set[0])
		else $error("forced channel 1 event missing");
	a_chan1_dma: assert property (
		ch_set[0] && dma_en[tmr_pkg::DMA_CH] |=> o_dma_req[0])
		else $error("channel 1 dma request missing");
	a_force_chan3: assert property (
		ceg[3] |=> ch_flag[2])
		else $error("forced channel 3 event missing");
	a_reserved_zero: assert property (
		i_rd && i_addr == tmr_pkg::ADDR_STS |=>
		o_rdata[8] == 1'b0 && o_rdata[15:13] == 3'h0)
		else $error("reserved status bits not zero");

endmodule : timer_status_evgen

// [sim/tb_top.sv]
`timescale 1ns/1ps
module tb_top;

	// ----------------------------------------------------------
	// Stimulus and observation signals.
	// ----------------------------------------------------------
	logic i_ref_clk;
	logic i_nrst;
	logic [7:0] i_addr;
	logic [15:0] i_wdata;
	logic i_wr;
	logic i_rd;
	logic [15:0] o_rdata;
	logic i_trigger_evt;
	logic i_commutation_evt;
	logic i_brake_pin;
	logic [3:0] i_chan_pin;
	logic o_irq;
	logic [3:0] o_dma_req;
	logic o_update_evt;
	logic [15:0] o_counter;
	int n_fail;
	int checked;
	int cyc;
	logic [15:0] d;

	timer_status_evgen dut_u (
		.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_trigger_evt(i_trigger_evt),
		.i_commutation_evt(i_commutation_evt),
		.i_brake_pin(i_brake_pin), .i_chan_pin(i_chan_pin),
		.o_irq(o_irq), .o_dma_req(o_dma_req),
		.o_update_evt(o_update_evt), .o_counter(o_counter)
	);

	// The 8 ns clock.
	initial begin
		i_ref_clk = 1'b0;
		forever #4 i_ref_clk = ~i_ref_clk;
	end

	// ----------------------------------------------------------
	// Shared tasks.
	// ----------------------------------------------------------
	// Prints the verdict and stops the run.
	task automatic close_out();
		if (n_fail == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : close_out

	// Compares with case inequality so an unknown never matches.
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// Lands past the edge so its updates have settled.
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge i_ref_clk);
		#1;
	endtask : wait_cyc

	// One-cycle write strobe.
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge i_ref_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= v;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe.
	task automatic rd(input logic [7:0] a, output logic [15:0] v);
		@(posedge i_ref_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1;
		v = o_rdata;
	endtask : rd

	// ----------------------------------------------------------
	// Scenarios.
	// ----------------------------------------------------------
	// Forced update reloads or zeroes the counter by mode.
	task automatic t_update();
		logic [15:0] mode [4];
		logic [15:0] cnt [4];
		mode = '{16'h0002, 16'h0000, 16'h0002, 16'h0004};
		cnt = '{16'h0055, 16'h0000, 16'h0055, 16'h0000};
		wr(8'h2C, 16'h0055);
		wr(8'h28, 16'h0003);
		for (int i = 0; i < 4; i++) begin
			wr(8'h00, mode[i]);
			wr(8'h10, 16'h0000);
			wr(8'h14, 16'h0001);
			wait_cyc(1);
			chk({15'h0000, o_update_evt}, 16'h0001);
			chk(o_counter, cnt[i]);
			wait_cyc(1);
			chk({15'h0000, o_update_evt}, 16'h0000);
			rd(8'h10, d);
			chk(d, 16'h0001);
			rd(8'h14, d);
			chk(d, 16'h0000);
		end
		// The division factor survives every update.
		rd(8'h28, d);
		chk(d, 16'h0003);
	endtask : t_update

	// Forced events on output channels 1 to 3 raise flag and DMA.
	task automatic t_force_out();
		wr(8'h00, 16'h0000);
		wr(8'h08, 16'h001E);
		for (int ch = 1; ch < 4; ch++) begin
			wr(8'h10, 16'h0000);
			wr(8'h14, 16'h0001 << ch);
			wait_cyc(2);
			chk({12'h000, o_dma_req}, 16'h0001 << (ch - 1));
			chk({15'h0000, o_irq}, 16'h0000);
			rd(8'h10, d);
			chk(d, 16'h0001 << ch);
		end
		wr(8'h08, 16'h0000);
	endtask : t_force_out

	// Forced capture twice, then the capture register read.
	task automatic t_force_in();
		wr(8'h00, 16'h0012);
		wr(8'h14, 16'h0001);
		wr(8'h10, 16'h0000);
		// Drop events left pending by the earlier scenarios.
		rd(8'h44, d);
		wr(8'h0C, 16'h0002);
		wr(8'h14, 16'h0002);
		wait_cyc(2);
		chk({15'h0000, o_irq}, 16'h0001);
		rd(8'h44, d);
		chk(d, 16'h0002);
		wr(8'h14, 16'h0002);
		rd(8'h10, d);
		chk(d, 16'h0202);
		rd(8'h34, d);
		chk(d, 16'h0055);
		rd(8'h10, d);
		chk(d, 16'h0200);
		wr(8'h0C, 16'h0000);
		wr(8'h10, 16'h0000);
		rd(8'h44, d);
	endtask : t_force_in

	// Trigger under the mask, commutation outside it.
	task automatic t_events();
		wr(8'h0C, 16'h0040);
		@(posedge i_ref_clk);
		i_trigger_evt <= 1'b1;
		@(posedge i_ref_clk);
		i_trigger_evt <= 1'b0;
		wait_cyc(3);
		chk({15'h0000, o_irq}, 16'h0001);
		rd(8'h44, d);
		chk(d, 16'h0040);
		wait_cyc(1);
		chk({15'h0000, o_irq}, 16'h0000);
		@(posedge i_ref_clk);
		i_commutation_evt <= 1'b1;
		@(posedge i_ref_clk);
		i_commutation_evt <= 1'b0;
		wait_cyc(3);
		chk({15'h0000, o_irq}, 16'h0000);
		rd(8'h10, d);
		chk(d, 16'h0060);
		// Writing ones keeps bits; reserved bits stay zero.
		wr(8'h10, 16'hFFBF);
		rd(8'h10, d);
		chk(d, 16'h0020);
		wr(8'h10, 16'h0000);
		wr(8'h0C, 16'h0000);
	endtask : t_events

	// A clear only sticks once the brake has gone away.
	task automatic t_brake();
		i_brake_pin <= 1'b1;
		repeat (8) @(posedge i_ref_clk);
		wr(8'h10, 16'h0000);
		rd(8'h10, d);
		chk(d, 16'h0080);
		@(posedge i_ref_clk);
		i_brake_pin <= 1'b0;
		repeat (8) @(posedge i_ref_clk);
		wr(8'h10, 16'h0000);
		rd(8'h10, d);
		chk(d, 16'h0000);
	endtask : t_brake

	// Pin captures on channels 3 and 4, the second one repeating.
	task automatic t_pins();
		wr(8'h00, 16'h00C0);
		wr(8'h10, 16'h0000);
		for (int i = 0; i < 2; i++) begin
			@(posedge i_ref_clk);
			i_chan_pin <= 4'hC;
			repeat (8) @(posedge i_ref_clk);
			i_chan_pin <= 4'h0;
			repeat (8) @(posedge i_ref_clk);
			rd(8'h10, d);
			chk(d, (i == 0) ? 16'h0018 : 16'h1818);
		end
		wr(8'h10, 16'h0000);
		rd(8'h10, d);
		chk(d, 16'h0000);
		rd(8'hF0, d);
		chk(d, 16'h0000);
	endtask : t_pins

	// Free counting up wraps at the reload and hits a compare.
	task automatic t_count();
		wr(8'h28, 16'h0000);
		wr(8'h2C, 16'h0009);
		wr(8'h38, 16'h0004);
		wr(8'h00, 16'h0000);
		wr(8'h14, 16'h0001);
		wr(8'h10, 16'h0000);
		// Twelve ticks: ten to wrap from 9 to 0, then two more.
		wr(8'h00, 16'h0001);
		repeat (10) @(posedge i_ref_clk);
		wr(8'h00, 16'h0000);
		wait_cyc(1);
		chk(o_counter, 16'h0002);
		rd(8'h10, d);
		chk(d, 16'h0005);
	endtask : t_count

	// ----------------------------------------------------------
	// Main sequence and hang guard.
	// ----------------------------------------------------------
	initial begin
		n_fail = 0;
		checked = 0;
		i_nrst = 1'b0;
		i_addr = 8'h00;
		i_wdata = 16'h0000;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_trigger_evt = 1'b0;
		i_commutation_evt = 1'b0;
		i_brake_pin = 1'b0;
		i_chan_pin = 4'h0;
		repeat (10) @(posedge i_ref_clk);
		i_nrst <= 1'b1;
		@(posedge i_ref_clk);
		rd(8'h10, d);
		chk(d, 16'h0000);
		t_update();
		t_force_out();
		t_force_in();
		t_events();
		t_brake();
		t_pins();
		t_count();
		close_out();
	end

	// A run of this length means something has hung.
	initial begin
		cyc = 0;
		forever begin
			@(posedge i_ref_clk);
			cyc++;
			if (cyc == 20000) begin
				n_fail++;
				close_out();
			end
		end
	end

endmodule : tb_top
